/* File: slsi_pkg.sv */
// Package with constants and carrier types for the strap latch and status indicator block.
package slsi_pkg;

   // ****************************************************************
   // Sizes and reset values
   // ****************************************************************
   localparam int SLSI_NPINS = 5;
   localparam logic [4:0] SLSI_ADDR_RST = 5'h00;
   localparam logic [4:0] SLSI_ADDR_FLOAT = 5'h00;
   localparam logic [1:0] SLSI_SETTLE_RST = 2'h0;
   localparam logic [1:0] SLSI_SETTLE_CYC = 2'h2;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {
      SLSI_ST_RESET = 2'b00,
      SLSI_ST_SETTLE = 2'b01,
      SLSI_ST_DRIVE = 2'b10
   } slsi_state_t;

   // Indications in pin order: activity, collision, link ok, tx, rx.
   typedef struct packed {
      logic rx_active;
      logic tx_active;
      logic link_ok;
      logic collision;
      logic activity;
   } slsi_ind_t;

   typedef struct packed {
      logic [4:0] pin_o;
      logic [4:0] pin_oe;
   } slsi_pins_t;

   typedef struct packed {
      slsi_state_t state;
      logic [1:0] settle;
      logic [4:0] sync1;
      logic [4:0] sync2;
      logic [4:0] addr;
      logic addr_valid;
      slsi_pins_t pins;
   } slsi_regs_t;

endpackage

/* File: slsi_strap_led.sv */
// Dual-purpose strap and status indicator pins with management address capture.
`timescale 1ns/1ps

// Operation
// - Pins are inputs during hardware reset; their level is captured on the fourth clock edge after release.
// - After capture every pin becomes an indicator output.
// - Software reset neither recaptures nor changes pin direction.
// - Captured levels form the management address.
// - Asserted indication drives the pin opposite to its captured level.
// - Captured address zero floats the MAC-side media interface outputs.
// - Indicators follow activity, collision, link, transmit, receive in pin order.
module slsi_strap_led (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic soft_reset_i,
   // Strap and indicator pins
   input wire logic [4:0] strap_pin_i,
   output logic [4:0] strap_pin_o,
   output logic [4:0] strap_pin_oe_o,
   // Link monitoring indications
   input wire slsi_pkg::slsi_ind_t ind_i,
   // Management address and media interface control
   output logic [4:0] mgmt_addr_o,
   output logic addr_valid_o,
   output logic mii_float_o
);
   import slsi_pkg::*;

   slsi_regs_t q_r;
   slsi_regs_t q_nxt;

   // ****************************************************************
   // Indicator levels
   // ****************************************************************
   // A pin rests at its strapped level, which keeps its LED dark, and swings to
   // the opposite level only while its indication is asserted.
   function automatic logic slsi_drive_bit(input logic strapped, input logic asserted);
      logic level;
      level = strapped;
      if (asserted) begin
         level = ~strapped;
      end
      return level;
   endfunction

   logic [4:0] drive_lvl;

   for (genvar p = 0; p < SLSI_NPINS; p++) begin : g_pin
      assign drive_lvl[p] = slsi_drive_bit(q_r.addr[p], ind_i[p]);

      a_pin_drive: assert property (@(posedge clock_i) disable iff (!rstn_i)
         (q_r.state == SLSI_ST_DRIVE) |=> (strap_pin_o[p] == ($past(ind_i[p]) ? ~mgmt_addr_o[p] : mgmt_addr_o[p])))
         else $error("Indicator pin level wrong.");

      a_pin_to_bit: assert property (@(posedge clock_i) disable iff (!rstn_i)
         $rose(q_r.addr_valid) |-> (mgmt_addr_o[p] == $past(strap_pin_i[p], 3)))
         else $error("Address bit not taken from its own pin.");
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      q_nxt = q_r;
      q_nxt.sync1 = strap_pin_i;
      q_nxt.sync2 = q_r.sync1;
      case (q_r.state)
         SLSI_ST_RESET: begin
            // Pins stay inputs; wait for the synchroniser to fill after release.
            q_nxt.pins.pin_oe = '0;
            q_nxt.pins.pin_o = '0;
            q_nxt.addr = SLSI_ADDR_RST;
            q_nxt.addr_valid = 1'b0;
            q_nxt.settle = q_r.settle + 2'h1;
            if (q_r.settle == SLSI_SETTLE_CYC) begin
               q_nxt.state = SLSI_ST_SETTLE;
            end
         end
         SLSI_ST_SETTLE: begin
            q_nxt.pins.pin_oe = '0;
            q_nxt.addr = q_r.sync2;
            q_nxt.addr_valid = 1'b1;
            q_nxt.state = SLSI_ST_DRIVE;
         end
         SLSI_ST_DRIVE: begin
            // Software reset is not a term here, so direction and address hold.
            q_nxt.pins.pin_oe = '1;
            q_nxt.pins.pin_o = drive_lvl;
         end
         default: begin
            q_nxt.state = SLSI_ST_RESET;
         end
      endcase
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         q_r.state <= SLSI_ST_RESET;
         q_r.settle <= SLSI_SETTLE_RST;
         q_r.sync1 <= '0;
         q_r.sync2 <= '0;
         q_r.addr <= SLSI_ADDR_RST;
         q_r.addr_valid <= 1'b0;
         q_r.pins <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign strap_pin_o = q_r.pins.pin_o;
   assign strap_pin_oe_o = q_r.pins.pin_oe;
   assign mgmt_addr_o = q_r.addr;
   assign addr_valid_o = q_r.addr_valid;
   assign mii_float_o = q_r.addr_valid && (q_r.addr == SLSI_ADDR_FLOAT);

   // ****************************************************************
   // Assertions
   // ****************************************************************
   a_inputs_before_capture: assert property (@(posedge clock_i) disable iff (!rstn_i)
      !q_r.addr_valid |-> strap_pin_oe_o == 5'h00)
      else $error("Pins driven before address capture.");

   a_outputs_after_capture: assert property (@(posedge clock_i) disable iff (!rstn_i)
      $rose(q_r.addr_valid) |=> strap_pin_oe_o == 5'h1f)
      else $error("Pins not switched to outputs after capture.");

   a_soft_reset_holds: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (strap_pin_oe_o == 5'h1f && soft_reset_i) |=> (strap_pin_oe_o == 5'h1f && $stable(mgmt_addr_o)))
      else $error("Software reset disturbed the pins.");

   a_addr_from_pins: assert property (@(posedge clock_i) disable iff (!rstn_i)
      $rose(q_r.addr_valid) |-> mgmt_addr_o == $past(q_r.sync2))
      else $error("Address differs from sampled pins.");

   a_addr_stable: assert property (@(posedge clock_i) disable iff (!rstn_i)
      q_r.addr_valid |=> $stable(mgmt_addr_o))
      else $error("Address changed after capture.");

   a_inverted_drive: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (q_r.state == SLSI_ST_DRIVE) |=> strap_pin_o == (mgmt_addr_o ^ $past(ind_i)))
      else $error("Indicator level not inverted from strap.");

   a_float_zero: assert property (@(posedge clock_i) disable iff (!rstn_i)
      q_r.addr_valid |-> (mii_float_o == (mgmt_addr_o == 5'h00)))
      else $error("Media interface float wrong.");

   a_capture_time: assert property (@(posedge clock_i) disable iff (!rstn_i)
      $rose(rstn_i) |-> ##[1:6] q_r.addr_valid)
      else $error("Capture not finished in time.");

   // ****************************************************************
   // Capture sequence
   // ****************************************************************
   // Release, four edges with the pins still inputs, then capture, then drive.
   sequence s_release;
      $rose(rstn_i);
   endsequence

   sequence s_inputs_held;
      (!q_r.addr_valid && (strap_pin_oe_o == 5'h00)) [*4];
   endsequence

   sequence s_captured;
      q_r.addr_valid && (strap_pin_oe_o == 5'h00);
   endsequence

   sequence s_driving;
      q_r.addr_valid && (strap_pin_oe_o == 5'h1f);
   endsequence

   a_capture_walk: assert property (@(posedge clock_i) disable iff (!rstn_i)
      s_release |-> s_inputs_held ##1 s_captured ##1 s_driving)
      else $error("Capture steps out of order.");

   a_settle_order: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (q_r.state == SLSI_ST_SETTLE) |-> ($past(q_r.state) == SLSI_ST_RESET))
      else $error("Capture entered without the settle wait.");

   a_pins_low_before: assert property (@(posedge clock_i) disable iff (!rstn_i)
      !q_r.addr_valid |-> (strap_pin_o == 5'h00))
      else $error("Pin level set before address capture.");

   // ****************************************************************
   // Drive and float checks
   // ****************************************************************
   a_oe_hold: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (q_r.addr_valid && $past(q_r.addr_valid)) |-> (strap_pin_oe_o == 5'h1f))
      else $error("Pins left output mode after capture.");

   a_oe_uniform: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (strap_pin_oe_o == 5'h00) || (strap_pin_oe_o == 5'h1f))
      else $error("Pins switched direction one by one.");

   a_valid_sticky: assert property (@(posedge clock_i) disable iff (!rstn_i)
      q_r.addr_valid |=> q_r.addr_valid)
      else $error("Captured address dropped without hardware reset.");

   a_soft_no_capture: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (soft_reset_i && (q_r.state == SLSI_ST_DRIVE)) |=> (q_r.state == SLSI_ST_DRIVE))
      else $error("Software reset restarted the capture.");

   a_dark_when_idle: assert property (@(posedge clock_i) disable iff (!rstn_i)
      ((q_r.state == SLSI_ST_DRIVE) && (ind_i == 5'h00)) |=> (strap_pin_o == mgmt_addr_o))
      else $error("Idle indicator not at strapped level.");

   a_lit_when_all: assert property (@(posedge clock_i) disable iff (!rstn_i)
      ((q_r.state == SLSI_ST_DRIVE) && (ind_i == 5'h1f)) |=> (strap_pin_o == ~mgmt_addr_o))
      else $error("Asserted indicators not at inverted level.");

   a_float_before: assert property (@(posedge clock_i) disable iff (!rstn_i)
      !q_r.addr_valid |-> !mii_float_o)
      else $error("Media interface floated before capture.");

   a_float_stable: assert property (@(posedge clock_i) disable iff (!rstn_i)
      q_r.addr_valid |=> $stable(mii_float_o))
      else $error("Media interface float changed after capture.");
endmodule

/* File: slsi_strap_model.sv */
// Strap resistors and indicator loads on the five dual-purpose pins.
`timescale 1ns/1ps
module slsi_strap_model (
   // Strap setting and pin wires
   input wire logic [4:0] strap_i,
   input wire logic [4:0] pin_o_i,
   input wire logic [4:0] pin_oe_i,
   output logic [4:0] level_o
);
   // A pin that is not driven settles to its pull resistor.
   assign level_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & strap_i);
endmodule

/* File: slsi_strap_led_tb_top.sv */
// Self-checking bench for the strap latch and status indicator block.
`timescale 1ns/1ps
module slsi_strap_led_tb_top;
   import slsi_pkg::*;
   logic clock_i = 1'b0;
   logic rstn_i = 1'b0;
   logic soft_reset_i = 1'b0;
   logic [4:0] strap = 5'h00;
   logic [4:0] level, pin_o, pin_oe, addr;
   logic addr_valid, mii_float;
   slsi_ind_t ind = '0;
   int miscompares = 0;
   int check_count = 0;
   int cycles = 0;
   initial forever #20 clock_i = ~clock_i;
   slsi_strap_model pull (.strap_i(strap), .pin_o_i(pin_o), .pin_oe_i(pin_oe), .level_o(level));
   slsi_strap_led dut (.clock_i(clock_i), .rstn_i(rstn_i), .soft_reset_i(soft_reset_i), .strap_pin_i(level),
      .strap_pin_o(pin_o), .strap_pin_oe_o(pin_oe), .ind_i(ind), .mgmt_addr_o(addr),
      .addr_valid_o(addr_valid), .mii_float_o(mii_float));
   task check(input logic [5:0] seen, input logic [5:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task close_out;
      if (miscompares == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task test_capture(input logic [4:0] s);
      @(negedge clock_i);
      rstn_i = 1'b0;
      strap = s;
      repeat (4) @(negedge clock_i);
      check({1'b0, pin_oe}, 6'h00);
      rstn_i = 1'b1;
      repeat (8) @(negedge clock_i);
      check({addr_valid, addr}, {1'b1, s});
      check({mii_float, pin_oe}, {s == 5'h00, 5'h1f});
   endtask
   task test_drive(input logic [4:0] s);
      logic [4:0] one;
      for (int i = 0; i < 5; i++) begin
         one = 5'h01 << i;
         ind = one;
         @(negedge clock_i);
         @(negedge clock_i);
         check({1'b0, pin_o}, {1'b0, s ^ one});
      end
      ind = '0;
      repeat (2) @(negedge clock_i);
      check({1'b0, pin_o}, {1'b0, s});
   endtask
   task test_soft(input logic [4:0] s);
      soft_reset_i = 1'b1;
      strap = ~s;
      ind = 5'h1f;
      repeat (6) @(negedge clock_i);
      check({1'b0, pin_oe}, 6'h1f);
      check({addr_valid, addr}, {1'b1, s});
      check({1'b0, pin_o}, {1'b0, ~s});
      soft_reset_i = 1'b0;
      ind = '0;
   endtask
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 2000) begin
         miscompares++;
         close_out();
      end
   end
   initial begin
      test_capture(5'h15);
      test_drive(5'h15);
      test_soft(5'h15);
      test_capture(5'h0a);
      test_drive(5'h0a);
      test_capture(5'h00);
      test_drive(5'h00);
      close_out();
   end
endmodule
